// ### hw/ebt_cfg.svh
// Function
// (R1) force strobe works only in non-PWM modes
// (R2) force strobe applies an immediate compare match
// (R3) forced match sets no flag, no clear
// (R4) force strobe always reads as zero
// (R5) software writes force zero in PWM modes
// (R6) mode field split over bits 6, 3
// (R7) TOP and compare update timing per mode
// (R8) overflow at BOTTOM or MAX per mode
// (R9) active output mode overrides pin, direction enables
// (R10) non-PWM: off, toggle, clear, set on match
// (R11) fast PWM: clear/set on match, opposite at TOP
// (R12) phase PWM: action depends on count direction
// (R13) compare equal TOP: act at TOP only
// (R14) clock select stops or divides source clock
// (R15) count register directly readable and writable
// (R16) count write suppresses next tick's match
// (R17) continuous compare sets flag, drives waveform
// (R18) clear-on-match mode clears count on match
// (R19) timer clock is an enable, not clock
// (R20) phase PWM extremes hold output constant
// (R21) reserved output mode acts as disconnected
// (R22) count, compare, waveform reset to zero
`ifndef EBT_CFG_SVH
`define EBT_CFG_SVH
`define EBT_ADDR_W 5
`define EBT_OFS_CONTROL 5'h00
`define EBT_OFS_COUNT 5'h04
`define EBT_OFS_COMPARE 5'h08
`define EBT_OFS_STATUS 5'h0C
`define EBT_OFS_PORT 5'h10
`define EBT_BIT_FORCE 7
`define EBT_BIT_WGM_LO 6
`define EBT_BIT_COM_HI 5
`define EBT_BIT_COM_LO 4
`define EBT_BIT_WGM_HI 3
`define EBT_BIT_CS_HI 2
`define EBT_BIT_OVF 0
`define EBT_BIT_CMP 1
`define EBT_BIT_PORT_DIR 0
`define EBT_BIT_PORT_VAL 1
`define EBT_RST_CONTROL 7'h00
`define EBT_RST_COUNT 8'h00
`define EBT_RST_COMPARE 8'h00
`define EBT_MAX 8'hFF
`define EBT_BOTTOM 8'h00
`define EBT_PRESCALE_W 10
`define EBT_MASK_DIV8 10'h007
`define EBT_MASK_DIV32 10'h01F
`define EBT_MASK_DIV64 10'h03F
`define EBT_MASK_DIV128 10'h07F
`define EBT_MASK_DIV256 10'h0FF
`define EBT_MASK_DIV1024 10'h3FF
`define EBT_RESP_OKAY 2'h0
`define EBT_RESP_SLVERR 2'h2
`endif

// ### hw/ebt_pkg.sv
`include "ebt_cfg.svh"
package ebt_pkg;
    // waveform mode, in field value order
    typedef enum logic [1:0] {
        WM_NORMAL,
        WM_PHASE_PWM,
        WM_CLEAR_ON_MATCH,
        WM_FAST_PWM
    } ebt_wmode_t;
endpackage

// ### hw/ebt_timer.sv
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`include "ebt_cfg.svh"
module ebt_timer
    import ebt_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic [`EBT_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`EBT_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic waveformPinOut,
    output logic waveformPinOe,
    output logic compareMatchFlag,
    output logic overflowFlag
);

    // prescaler tick for a clock select value
    function automatic logic sel_tick(
        input logic [2:0] sel,
        input logic [`EBT_PRESCALE_W-1:0] pre
    );
        logic [`EBT_PRESCALE_W-1:0] mask;
        mask = '0;
        unique case (sel)
            3'h2: mask = `EBT_MASK_DIV8;
            3'h3: mask = `EBT_MASK_DIV32;
            3'h4: mask = `EBT_MASK_DIV64;
            3'h5: mask = `EBT_MASK_DIV128;
            3'h6: mask = `EBT_MASK_DIV256;
            3'h7: mask = `EBT_MASK_DIV1024;
            default: mask = '0;
        endcase
        return (sel != 3'h0) && ((pre & mask) == mask);
    endfunction

    // level for a set/clear action code
    function automatic logic act_level(
        input logic [1:0] com,
        input logic cur
    );
        logic lvl;
        lvl = cur;
        unique case (com)
            2'h1: lvl = ~cur;
            2'h2: lvl = 1'b0;
            2'h3: lvl = 1'b1;
            default: lvl = cur;
        endcase
        return lvl;
    endfunction

    logic [6:0] ctrlQ;
    logic [7:0] cntQ, cntD;
    logic [7:0] cmpBufQ;
    logic [7:0] cmpActQ, cmpActD;
    logic upQ, upD;
    logic blockQ;
    logic waveQ, waveD;
    logic cmpFlagQ, ovfFlagQ;
    logic portDirQ, portValQ;
    logic [`EBT_PRESCALE_W-1:0] preQ;
    logic bvalidQ, rvalidQ;
    logic [1:0] brespQ, rrespQ;
    logic [31:0] rdataQ;

    // control field decode
    wire ebt_wmode_t wmode = ebt_wmode_t'({ctrlQ[`EBT_BIT_WGM_HI], ctrlQ[`EBT_BIT_WGM_LO]}); // R6
    wire logic [1:0] com = ctrlQ[`EBT_BIT_COM_HI:`EBT_BIT_COM_LO];
    wire logic [2:0] csSel = ctrlQ[`EBT_BIT_CS_HI:0];
    wire logic isPwm = (wmode == WM_PHASE_PWM) || (wmode == WM_FAST_PWM);
    wire logic isPhase = (wmode == WM_PHASE_PWM);

    // timer clock as an enable on clk_sys
    wire logic tick = sel_tick(csSel, preQ); // R14 R19

    // top value and compare detection
    wire logic [7:0] topVal = (wmode == WM_CLEAR_ON_MATCH) ? cmpActQ : `EBT_MAX; // R7
    wire logic atMax = (cntQ == `EBT_MAX);
    wire logic atBottom = (cntQ == `EBT_BOTTOM);
    wire logic atTop = (cntQ == topVal);
    wire logic matchRaw = (cntQ == cmpActQ); // R17
    wire logic matchEv = tick && matchRaw && !blockQ; // R16 R17
    wire logic ovfEv = tick && (isPhase ? atBottom : atMax); // R8

    // bus write decode
    wire logic wrFire = clkEn && s_axi_awvalid && s_axi_wvalid && !bvalidQ;
    wire logic [`EBT_ADDR_W-1:0] wAddr = {s_axi_awaddr[`EBT_ADDR_W-1:2], 2'b00};
    wire logic wrLane = wrFire && s_axi_wstrb[0];
    wire logic wrCtrl = wrLane && (wAddr == `EBT_OFS_CONTROL);
    wire logic wrCnt = wrLane && (wAddr == `EBT_OFS_COUNT);
    wire logic wrCmp = wrLane && (wAddr == `EBT_OFS_COMPARE);
    wire logic wrStat = wrLane && (wAddr == `EBT_OFS_STATUS);
    wire logic wrPort = wrLane && (wAddr == `EBT_OFS_PORT);
    wire logic wrMapped = (wAddr == `EBT_OFS_CONTROL) || (wAddr == `EBT_OFS_COUNT) ||
        (wAddr == `EBT_OFS_COMPARE) || (wAddr == `EBT_OFS_STATUS) || (wAddr == `EBT_OFS_PORT);
    wire logic [7:0] wByte = s_axi_wdata[7:0];

    // forced compare uses the mode and output mode being written
    wire logic [1:0] wrMode = {wByte[`EBT_BIT_WGM_HI], wByte[`EBT_BIT_WGM_LO]};
    wire logic wrNonPwm = (wrMode == 2'h0) || (wrMode == 2'h2);
    wire logic forceEv = wrCtrl && wByte[`EBT_BIT_FORCE] && wrNonPwm; // R1 R5
    wire logic [1:0] forceCom = wByte[`EBT_BIT_COM_HI:`EBT_BIT_COM_LO];

    // bus read decode
    wire logic rdFire = clkEn && s_axi_arvalid && !rvalidQ;
    wire logic [`EBT_ADDR_W-1:0] rAddr = {s_axi_araddr[`EBT_ADDR_W-1:2], 2'b00};
    wire logic rdCtrl = (rAddr == `EBT_OFS_CONTROL);
    wire logic rdCnt = (rAddr == `EBT_OFS_COUNT);
    wire logic rdCmp = (rAddr == `EBT_OFS_COMPARE);
    wire logic rdStat = (rAddr == `EBT_OFS_STATUS);
    wire logic rdPort = (rAddr == `EBT_OFS_PORT);
    wire logic rdMapped = rdCtrl || rdCnt || rdCmp || rdStat || rdPort;
    wire logic [7:0] rdByte =
        rdCtrl ? {1'b0, ctrlQ} : // R4
        rdCnt ? cntQ : // R15
        rdCmp ? cmpBufQ :
        rdStat ? {6'h00, cmpFlagQ, ovfFlagQ} :
        rdPort ? {6'h00, portValQ, portDirQ} : 8'h00;

    // status clear, a new event wins over the clear
    wire logic clrCmp = wrStat && wByte[`EBT_BIT_CMP];
    wire logic clrOvf = wrStat && wByte[`EBT_BIT_OVF];

    // handshake outputs
    assign s_axi_awready = wrFire;
    assign s_axi_wready = wrFire;
    assign s_axi_arready = rdFire;
    assign s_axi_bvalid = bvalidQ;
    assign s_axi_bresp = brespQ;
    assign s_axi_rvalid = rvalidQ;
    assign s_axi_rresp = rrespQ;
    assign s_axi_rdata = rdataQ;

    // pin override and driver enable
    wire logic comReserved = isPwm && (com == 2'h1); // R21
    wire logic connected = (com != 2'h0) && !comReserved; // R9
    assign waveformPinOut = connected ? waveQ : portValQ; // R9
    assign waveformPinOe = portDirQ; // R9
    assign compareMatchFlag = cmpFlagQ;
    assign overflowFlag = ovfFlagQ;

    // counter next value and direction
    always_comb begin
        cntD = cntQ;
        upD = upQ;
        if (wrCnt) begin
            cntD = wByte; // R15
        end else if (tick) begin
            unique case (wmode)
                WM_CLEAR_ON_MATCH: cntD = matchEv ? `EBT_BOTTOM : cntQ + 8'h01; // R18
                WM_PHASE_PWM: begin
                    if (upQ) begin
                        cntD = atMax ? cntQ - 8'h01 : cntQ + 8'h01;
                        upD = !atMax;
                    end else begin
                        cntD = atBottom ? cntQ + 8'h01 : cntQ - 8'h01;
                        upD = atBottom;
                    end
                end
                default: cntD = cntQ + 8'h01;
            endcase
        end
        if (!isPhase) begin
            upD = 1'b1;
        end
    end

    // active compare value: direct outside PWM, at TOP in PWM
    always_comb begin
        cmpActD = cmpActQ;
        if (!isPwm) begin
            cmpActD = wrCmp ? wByte : cmpBufQ; // R7
        end else if (tick && atMax) begin
            cmpActD = cmpBufQ; // R7
        end
    end

    // waveform generator
    always_comb begin
        waveD = waveQ;
        if (forceEv) begin
            waveD = act_level(forceCom, waveQ); // R2 R3
        end else if (tick) begin
            unique case (wmode)
                WM_FAST_PWM: begin
                    if (com[1] && atMax) begin
                        waveD = ~com[0]; // R11 R13
                    end else if (com[1] && matchEv && (cmpActQ != `EBT_MAX)) begin
                        waveD = com[0]; // R11 R13
                    end
                end
                WM_PHASE_PWM: begin
                    if (com[1] && (cmpActQ == `EBT_BOTTOM)) begin
                        waveD = com[0]; // R20
                    end else if (com[1] && (cmpActQ == `EBT_MAX)) begin
                        waveD = ~com[0]; // R20 R13
                    end else if (com[1] && matchEv) begin
                        waveD = upQ ? com[0] : ~com[0]; // R12
                    end
                end
                default: begin
                    if (matchEv) begin
                        waveD = act_level(com, waveQ); // R10 R17
                    end
                end
            endcase
        end
    end

    // prescaler counter
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            preQ <= '0;
        end else if (clkEn) begin
            preQ <= (csSel == 3'h0) ? '0 : preQ + 1'b1;
        end
    end

    // timer core registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cntQ <= `EBT_RST_COUNT; // R22
            cmpActQ <= `EBT_RST_COMPARE; // R22
            upQ <= 1'b1;
            waveQ <= 1'b0; // R22
            blockQ <= 1'b0;
        end else if (clkEn) begin
            cntQ <= cntD;
            cmpActQ <= cmpActD;
            upQ <= upD;
            waveQ <= waveD;
            blockQ <= wrCnt ? 1'b1 : (tick ? 1'b0 : blockQ); // R16
        end
    end

    // software registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrlQ <= `EBT_RST_CONTROL;
            cmpBufQ <= `EBT_RST_COMPARE; // R22
            portDirQ <= 1'b0;
            portValQ <= 1'b0;
        end else if (clkEn) begin
            if (wrCtrl) begin
                ctrlQ <= wByte[6:0]; // R4
            end
            if (wrCmp) begin
                cmpBufQ <= wByte;
            end
            if (wrPort) begin
                portDirQ <= wByte[`EBT_BIT_PORT_DIR];
                portValQ <= wByte[`EBT_BIT_PORT_VAL];
            end
        end
    end

    // sticky event flags, forced compare never sets them
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cmpFlagQ <= 1'b0;
            ovfFlagQ <= 1'b0;
        end else if (clkEn) begin
            cmpFlagQ <= matchEv || (cmpFlagQ && !clrCmp); // R17 R3
            ovfFlagQ <= ovfEv || (ovfFlagQ && !clrOvf); // R8
        end
    end

    // write response channel
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bvalidQ <= 1'b0;
            brespQ <= `EBT_RESP_OKAY;
        end else if (clkEn) begin
            if (wrFire) begin
                bvalidQ <= 1'b1;
                brespQ <= wrMapped ? `EBT_RESP_OKAY : `EBT_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalidQ <= 1'b0;
            end
        end
    end

    // read data channel
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rvalidQ <= 1'b0;
            rrespQ <= `EBT_RESP_OKAY;
            rdataQ <= 32'h0000_0000;
        end else if (clkEn) begin
            if (rdFire) begin
                rvalidQ <= 1'b1;
                rrespQ <= rdMapped ? `EBT_RESP_OKAY : `EBT_RESP_SLVERR;
                rdataQ <= {24'h000000, rdByte};
            end else if (s_axi_rready) begin
                rvalidQ <= 1'b0;
            end
        end
    end

endmodule

// ### tb/ebt_timer_assertions.sv
`include "ebt_cfg.svh"
module ebt_timer_chk (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic [`EBT_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`EBT_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic waveformPinOe,
    input wire logic compareMatchFlag,
    input wire logic overflowFlag
);
    logic [`EBT_ADDR_W-1:0] lastRdAddr_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // address of the read in flight
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lastRdAddr_q <= 5'h00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            lastRdAddr_q <= s_axi_araddr;
        end
    end
    // bus answers and holding
    a_wr_chan_pair: assert property (s_axi_awready |-> s_axi_wready && s_axi_wvalid && !s_axi_bvalid)
        else $error("write channels not taken together");
    a_wr_answer_next: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
        else $error("write response late");
    a_rd_answer_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_clken_freezes: assert property (!clkEn |-> !s_axi_awready && !s_axi_arready)
        else $error("request taken while disabled");
    // register content rules
    a_upper_bytes_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bytes not zero");
    a_force_reads_zero: assert property (s_axi_rvalid && lastRdAddr_q == `EBT_OFS_CONTROL |-> !s_axi_rdata[7])
        else $error("force strobe read back as one");
    a_oe_needs_write: assert property ($changed(waveformPinOe) |-> $past(s_axi_awvalid && s_axi_awready))
        else $error("pin enable changed without write");
    a_cmp_flag_sticky: assert property ($fell(compareMatchFlag) |->
        $past(s_axi_awvalid && s_axi_awready && (s_axi_awaddr & 5'h1C) == `EBT_OFS_STATUS))
        else $error("compare flag cleared by itself");
    a_ovf_flag_sticky: assert property ($fell(overflowFlag) |->
        $past(s_axi_awvalid && s_axi_awready && (s_axi_awaddr & 5'h1C) == `EBT_OFS_STATUS))
        else $error("overflow flag cleared by itself");
endmodule
bind ebt_timer ebt_timer_chk u_chk (.clk_sys, .resetn, .clkEn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .waveformPinOe, .compareMatchFlag, .overflowFlag);

// ### tb/testbench.sv
`include "ebt_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] OK = `EBT_RESP_OKAY;
    localparam logic [7:0] FCTL [4] = '{8'h90, 8'h90, 8'hB0, 8'hA0};
    localparam logic [7:0] PCNT [4] = '{8'h7E, 8'hFD, 8'hFD, 8'h7E};
    localparam logic [7:0] PCTL [4] = '{8'h69, 8'h69, 8'h79, 8'h79};
    localparam int DIVS [6] = '{8, 32, 64, 128, 256, 1024};
    logic clk_sys = 1'h0;
    logic resetn = 1'h0;
    logic clkEn = 1'h1;
    logic [`EBT_ADDR_W-1:0] s_axi_awaddr = 5'h00;
    logic [`EBT_ADDR_W-1:0] s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, d;
    logic waveformPinOut, waveformPinOe, compareMatchFlag, overflowFlag;
    int fails = 0;
    int checked = 0;
    // clock source
    always #5 clk_sys = ~clk_sys;
    ebt_timer dut (.clk_sys, .resetn, .clkEn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .waveformPinOut, .waveformPinOe,
        .compareMatchFlag, .overflowFlag);
    // compare seen against expected
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, seen, exp);
        end
    endtask
    // one write, response checked
    task automatic wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do @(posedge clk_sys); while (!s_axi_awready);
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid <= 1'h0;
        do @(posedge clk_sys); while (!s_axi_bvalid);
        s_axi_bready <= 1'h1;
        @(posedge clk_sys);
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, er);
    endtask
    // one read, response checked
    task automatic rd(input logic [4:0] a, input logic [1:0] er, output logic [31:0] v);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge clk_sys); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge clk_sys); while (!s_axi_rvalid);
        s_axi_rready <= 1'h1;
        @(posedge clk_sys);
        s_axi_rready <= 1'h0;
        v = s_axi_rdata;
        chk(s_axi_rresp, er);
    endtask
    // start the timer, wait, then stop it keeping the mode
    task automatic runFor(input logic [7:0] ctl, input int n);
        wr(`EBT_OFS_CONTROL, {24'h0, ctl}, OK);
        repeat (n) @(posedge clk_sys);
        wr(`EBT_OFS_CONTROL, {24'h0, ctl & 8'hF8}, OK);
    endtask
    task automatic print_verdict();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        repeat (30000) @(posedge clk_sys);
        fails++;
        print_verdict();
    end
    // main sequence
    initial begin
        repeat (4) @(posedge clk_sys);
        resetn <= 1'h1;
        for (int i = 0; i < 6; i++) begin
            rd(5'(i * 4), (i == 5) ? `EBT_RESP_SLVERR : OK, d);
            chk(d, 32'h0);
        end
        wr(5'h14, 32'hFF, `EBT_RESP_SLVERR);
        wr(`EBT_OFS_PORT, 32'h3, OK);
        chk(waveformPinOe, 1'h1);
        chk(waveformPinOut, 1'h1);
        wr(`EBT_OFS_PORT, 32'h1, OK);
        for (int i = 0; i < 4; i++) begin
            wr(`EBT_OFS_CONTROL, {24'h0, FCTL[i]}, OK);
            chk(waveformPinOut, 32'(i % 2 == 0));
            chk(compareMatchFlag, 1'h0);
        end
        rd(`EBT_OFS_CONTROL, OK, d);
        chk(d, 32'h20);
        wr(`EBT_OFS_COMPARE, 32'h5, OK);
        wr(`EBT_OFS_COUNT, 32'h5, OK);
        wr(`EBT_OFS_CONTROL, 32'hA8, OK);
        rd(`EBT_OFS_COUNT, OK, d);
        chk(d, 32'h5);
        chk(compareMatchFlag, 1'h0);
        wr(`EBT_OFS_COMPARE, 32'h3, OK);
        wr(`EBT_OFS_COUNT, 32'h0, OK);
        runFor(8'h09, 20);
        rd(`EBT_OFS_COUNT, OK, d);
        chk(d[31:2], 30'h0);
        chk({overflowFlag, compareMatchFlag}, 2'h1);
        wr(`EBT_OFS_STATUS, 32'h3, OK);
        chk({overflowFlag, compareMatchFlag}, 2'h0);
        wr(`EBT_OFS_COMPARE, 32'h10, OK);
        wr(`EBT_OFS_COUNT, 32'h10, OK);
        runFor(8'h01, 2);
        chk(compareMatchFlag, 1'h0);
        wr(`EBT_OFS_COUNT, 32'h0F, OK);
        runFor(8'h01, 2);
        chk(compareMatchFlag, 1'h1);
        wr(`EBT_OFS_COUNT, 32'hFE, OK);
        runFor(8'h01, 2);
        rd(`EBT_OFS_STATUS, OK, d);
        chk(d, 32'h3);
        wr(`EBT_OFS_STATUS, 32'h3, OK);
        wr(`EBT_OFS_COUNT, 32'hFE, OK);
        runFor(8'h41, 0);
        chk(overflowFlag, 1'h0);
        runFor(8'h41, 260);
        chk(overflowFlag, 1'h1);
        wr(`EBT_OFS_CONTROL, 32'hB0, OK);
        wr(`EBT_OFS_COMPARE, 32'h80, OK);
        wr(`EBT_OFS_CONTROL, 32'hE8, OK);
        wr(`EBT_OFS_CONTROL, 32'hE0, OK);
        chk(waveformPinOut, 1'h1);
        for (int i = 0; i < 4; i++) begin
            wr(`EBT_OFS_COUNT, {24'h0, PCNT[i]}, OK);
            runFor(PCTL[i], 2);
            chk(waveformPinOut, 32'(i % 2));
        end
        // reserved output mode leaves the pin to the port value
        wr(`EBT_OFS_CONTROL, 32'h58, OK);
        chk(waveformPinOut, 1'h0);
        // phase pwm: clear on the up match, set on the down match
        wr(`EBT_OFS_COUNT, 32'h7E, OK);
        runFor(8'h61, 2);
        chk(waveformPinOut, 1'h0);
        wr(`EBT_OFS_COUNT, 32'hFD, OK);
        runFor(8'h61, 200);
        chk(waveformPinOut, 1'h1);
        // phase pwm extremes hold the level at every tick
        for (int i = 0; i < 2; i++) begin
            wr(`EBT_OFS_CONTROL, 32'h0, OK);
            wr(`EBT_OFS_COMPARE, {24'h0, {8{i[0]}}}, OK);
            runFor(8'h61, 2);
            chk(waveformPinOut, 32'(i));
        end
        for (int i = 0; i < 6; i++) begin
            wr(`EBT_OFS_CONTROL, 32'h0, OK);
            wr(`EBT_OFS_COUNT, 32'h0, OK);
            runFor(8'(i + 2), DIVS[i] * 3);
            rd(`EBT_OFS_COUNT, OK, d);
            chk(32'(d >= 32'h2 && d <= 32'h4), 32'h1);
        end
        @(posedge clk_sys);
        clkEn <= 1'h0;
        fork
            wr(`EBT_OFS_COUNT, 32'h33, OK);
            begin
                repeat (6) @(posedge clk_sys);
                clkEn <= 1'h1;
            end
        join
        rd(`EBT_OFS_COUNT, OK, d);
        chk(d, 32'h33);
        print_verdict();
    end
endmodule
